//--- fdr_regs.svh
// Purpose: constants of the fault and diagnostic reporting block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef FDR_REGS_SVH
`define FDR_REGS_SVH

// ----------------------------------------
// short record, byte 0 bits
// ----------------------------------------
`define FDR_B0_MODULE_ERR 0
`define FDR_B0_INTERNAL 1
`define FDR_B0_EXTERNAL 2
`define FDR_B0_CHANNEL 3
`define FDR_B0_NO_PARAM 6
`define FDR_B0_BAD_PARAM 7
// ----------------------------------------
// short record, fixed bytes and bits
// ----------------------------------------
`define FDR_B1_VALUE 8'h18
`define FDR_B2_WATCHDOG 3
`define FDR_B3_HW_IRQ_LOST 6
// ----------------------------------------
// long record
// ----------------------------------------
`define FDR_SHORT_BYTES 4
`define FDR_LONG_BYTES 16
`define FDR_B4_CHAN_TYPE 8'h76
`define FDR_B5_INFO_LEN 8'h08
`define FDR_B6_NUM_CHAN 8'h08
`define FDR_CH_SUPPLY 4
`define FDR_CH_SIGNAL 6
`define FDR_NUM_CHAN 8

`endif

//--- fdr_pkg.sv
// Purpose: types of the fault and diagnostic reporting block
// Assumes: nothing
// Notes: no imports, use fdr_pkg::name
package fdr_pkg;

  // ----------------------------------------
  // error classes
  // ----------------------------------------
  typedef enum logic [2:0] {
    FDR_CLS_NONE,
    FDR_CLS_DATA,
    FDR_CLS_STATUS,
    FDR_CLS_MOD_PARAM,
    FDR_CLS_CHAN_PARAM,
    FDR_CLS_DIAG
  } fdr_class_t;

  // ----------------------------------------
  // fault sources, channel faults per channel
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] enc_signal;
    logic [7:0] enc_supply;
    logic bad_param;
    logic no_param;
    logic hw_irq_lost;
    logic watchdog;
  } fdr_fault_t;

  // ----------------------------------------
  // job toward one counting channel
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] channel;
    logic [31:0] cmp_val;
    logic [31:0] range_lo;
    logic [31:0] range_hi;
  } fdr_job_t;

endpackage

//--- fdr_core.sv
// Purpose: classifies faults, drives group fault indicator, diagnostic
//   interrupt, short and long diagnostic records, checks jobs
// Assumes: fault inputs come from pins, jobs and parameters from same clock
// Notes: one state struct, one next-state process, one register process
`timescale 1ns/1ps
`default_nettype none
`include "fdr_regs.svh"

module fdr_core #(
  parameter int NUM_CHAN = `FDR_NUM_CHAN
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // fault pins
  input wire fdr_pkg::fdr_fault_t fault_i,
  // parameter assignment
  input wire logic param_wr_i,
  input wire logic param_diag_en_i,
  input wire logic param_hw_en_i,
  // controller side
  input wire logic handler_installed_i,
  input wire logic hw_irq_req_i,
  // jobs
  input wire logic job_valid_i,
  input wire fdr_pkg::fdr_job_t job_i,
  // indication and interrupts
  output logic group_fault_indicator_o,
  output logic diag_irq_o,
  output logic hw_irq_o,
  output logic count_run_o,
  // records
  output logic [8*`FDR_SHORT_BYTES-1:0] short_diagnostic_record_o,
  output logic [8*`FDR_LONG_BYTES-1:0] long_diagnostic_record_o,
  // job answer
  output logic job_accept_o,
  output logic job_reject_o,
  output logic diag_buf_entry_o,
  output logic data_err_o,
  output fdr_pkg::fdr_class_t err_class_o
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (NUM_CHAN != `FDR_NUM_CHAN) begin : g_bad_chan
    $error("record layout serves exactly eight channels");
  end
  if (`FDR_LONG_BYTES != `FDR_SHORT_BYTES + 4 + NUM_CHAN) begin : g_bad_long
    $error("long record needs four header bytes and one byte per channel");
  end
  if (`FDR_SHORT_BYTES != 4) begin : g_bad_short
    $error("short record is four bytes and opens the long record");
  end
  if (`FDR_CH_SUPPLY > 7 || `FDR_CH_SIGNAL > 7) begin : g_bad_bit
    $error("channel bit positions must fall inside one byte");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    // pin synchroniser, then the settled fault set
    fdr_pkg::fdr_fault_t s1;
    fdr_pkg::fdr_fault_t s2;
    fdr_pkg::fdr_fault_t s3;
    fdr_pkg::fdr_fault_t stable;
    // enables written by parameter assignment
    logic diag_en;
    logic hw_en;
    // event waiting one cycle for its interrupt pulse
    logic diag_pending;
    // registered outputs
    logic indicator;
    logic diag_irq;
    logic hw_irq;
    logic count_run;
    logic [8*`FDR_SHORT_BYTES-1:0] short_rec;
    logic [8*`FDR_LONG_BYTES-1:0] long_rec;
    logic accept;
    logic reject;
    logic buf_entry;
    logic data_err;
    fdr_pkg::fdr_class_t cls;
  } fdr_state_t;

  fdr_state_t state_ff;
  fdr_state_t nxt_state;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic fdr_internal(input fdr_pkg::fdr_fault_t f);
    fdr_internal = f.watchdog | f.hw_irq_lost;
  endfunction

  // outside the module, but tied to no counting channel
  function automatic logic fdr_external(input fdr_pkg::fdr_fault_t f);
    fdr_external = f.no_param | f.bad_param;
  endfunction

  function automatic logic [7:0] fdr_chan_vec(input fdr_pkg::fdr_fault_t f);
    fdr_chan_vec = f.enc_supply | f.enc_signal;
  endfunction

  function automatic logic fdr_any(input fdr_pkg::fdr_fault_t f);
    fdr_any = fdr_internal(f) | fdr_external(f) | (|fdr_chan_vec(f));
  endfunction

  // ----------------------------------------
  // record assembly
  // ----------------------------------------
  logic [7:0] rec_b0;
  logic [7:0] rec_b1;
  logic [7:0] rec_b2;
  logic [7:0] rec_b3;
  logic [8*`FDR_SHORT_BYTES-1:0] rec_short;
  logic [8*(`FDR_LONG_BYTES-`FDR_SHORT_BYTES)-1:0] rec_tail;
  fdr_pkg::fdr_fault_t cur;

  assign cur = state_ff.stable;

  always_comb begin
    // byte 0 sorts the event: any, internal, external, channel, parameters
    rec_b0 = 8'h00;
    rec_b0[`FDR_B0_MODULE_ERR] = fdr_any(cur);
    rec_b0[`FDR_B0_INTERNAL] = fdr_internal(cur);
    rec_b0[`FDR_B0_EXTERNAL] = fdr_external(cur) | (|fdr_chan_vec(cur));
    rec_b0[`FDR_B0_CHANNEL] = |fdr_chan_vec(cur);
    rec_b0[`FDR_B0_NO_PARAM] = cur.no_param;
    rec_b0[`FDR_B0_BAD_PARAM] = cur.bad_param;
    // byte 1 is a fixed type code, bytes 2 and 3 name the internal cause
    rec_b1 = `FDR_B1_VALUE;
    rec_b2 = 8'h00;
    rec_b2[`FDR_B2_WATCHDOG] = cur.watchdog;
    rec_b3 = 8'h00;
    rec_b3[`FDR_B3_HW_IRQ_LOST] = cur.hw_irq_lost;
    rec_short = {rec_b3, rec_b2, rec_b1, rec_b0};
  end

  // per-channel bytes 8..15, then header bytes 4..7
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic [7:0] ch_byte;
    always_comb begin
      ch_byte = 8'h00;
      ch_byte[`FDR_CH_SUPPLY] = cur.enc_supply[c];
      ch_byte[`FDR_CH_SIGNAL] = cur.enc_signal[c];
    end
    assign rec_tail[32+8*c +: 8] = ch_byte;
  end
  logic [7:0] rec_b7;
  // byte 7 flags every channel that has an encoder fault
  assign rec_b7 = fdr_chan_vec(cur);
  assign rec_tail[31:0] = {rec_b7, `FDR_B6_NUM_CHAN, `FDR_B5_INFO_LEN, `FDR_B4_CHAN_TYPE};

  // ----------------------------------------
  // job check
  // ----------------------------------------
  logic job_range_bad;
  logic job_cmp_low;
  logic job_cmp_high;
  logic job_cmp_bad;

  // limits are signed counts; a reversed range is a channel parameter
  // fault rather than a data error, so it is tested first
  always_comb begin
    job_range_bad = $signed(job_i.range_lo) > $signed(job_i.range_hi);
    job_cmp_low = $signed(job_i.cmp_val) < $signed(job_i.range_lo);
    job_cmp_high = $signed(job_i.cmp_val) > $signed(job_i.range_hi);
    job_cmp_bad = job_cmp_low | job_cmp_high;
  end

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  logic fault_settled;
  logic fault_change;

  // stages two and three agree: the pin has held still for two cycles
  assign fault_settled = (state_ff.s2 == state_ff.s3);
  assign fault_change = fault_settled && (state_ff.s3 != state_ff.stable);

  // ----------------------------------------
  // next state
  // ----------------------------------------

  always_comb begin
    nxt_state = state_ff;
    // pin inputs: take a change once stages two and three agree; this
    // costs four cycles of latency but a pin that bounces for one cycle
    // never posts an interrupt pair
    nxt_state.s1 = fault_i;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    if (fault_settled) begin
      nxt_state.stable = state_ff.s3;
    end

    // enables cleared by reset, set only by parameter assignment
    if (param_wr_i) begin
      nxt_state.diag_en = param_diag_en_i;
      nxt_state.hw_en = param_hw_en_i;
    end

    // indicator follows the live fault set, also going out
    nxt_state.indicator = fdr_any(cur);

    // records track every event while it stands; they are rebuilt each
    // cycle, so a cleared fault leaves no stale bits behind
    nxt_state.short_rec = rec_short;
    nxt_state.long_rec = {rec_tail, rec_short};

    // one pulse per incoming or outgoing event; it lags the change by one
    // cycle so the records already hold the new event when it is seen
    nxt_state.diag_pending = fault_change;
    nxt_state.diag_irq = state_ff.diag_pending & state_ff.diag_en;
    // the hardware interrupt passes its own enable only
    nxt_state.hw_irq = hw_irq_req_i & state_ff.hw_en;

    // without a handler the controller stops, so counting halts
    nxt_state.count_run = !(fdr_any(cur) && !handler_installed_i);

    // job answer: pulses last one cycle, the class stays until the next event
    nxt_state.accept = 1'b0;
    nxt_state.reject = 1'b0;
    nxt_state.buf_entry = 1'b0;
    nxt_state.data_err = 1'b0;
    if (job_valid_i) begin
      if (job_range_bad) begin
        nxt_state.reject = 1'b1;
        nxt_state.buf_entry = 1'b1;
        nxt_state.cls = fdr_pkg::FDR_CLS_CHAN_PARAM;
      end else if (job_cmp_bad) begin
        nxt_state.reject = 1'b1;
        nxt_state.buf_entry = 1'b1;
        nxt_state.data_err = 1'b1;
        nxt_state.cls = fdr_pkg::FDR_CLS_DATA;
      end else begin
        nxt_state.accept = 1'b1;
        nxt_state.cls = fdr_pkg::FDR_CLS_STATUS;
      end
    end

    // a fault change outranks a job answer in the same cycle; the job's own
    // pulses still tell the controller what became of it
    if (fault_change) begin
      if (nxt_state.stable.no_param || nxt_state.stable.bad_param) begin
        nxt_state.cls = fdr_pkg::FDR_CLS_MOD_PARAM;
      end else begin
        nxt_state.cls = fdr_pkg::FDR_CLS_DIAG;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // synchronous reset clears the synchroniser too, so a pin that is
  // already faulty at release is reported as a fresh event
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      // both interrupt enables come up off; counting is free to run
      state_ff <= '0;
      state_ff.count_run <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // outputs are register fields, no logic after the flops
  assign group_fault_indicator_o = state_ff.indicator;
  assign diag_irq_o = state_ff.diag_irq;
  assign hw_irq_o = state_ff.hw_irq;
  assign count_run_o = state_ff.count_run;
  assign short_diagnostic_record_o = state_ff.short_rec;
  assign long_diagnostic_record_o = state_ff.long_rec;
  assign job_accept_o = state_ff.accept;
  assign job_reject_o = state_ff.reject;
  assign diag_buf_entry_o = state_ff.buf_entry;
  assign data_err_o = state_ff.data_err;
  assign err_class_o = state_ff.cls;

endmodule

`default_nettype wire

//--- fdr_monitor.sv
// Purpose: port checker of fdr_core
// Assumes: bound to every fdr_core
// Notes: pin to indicator latency is five edges
`timescale 1ns/1ps
`default_nettype none
module fdr_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire fdr_pkg::fdr_fault_t fault_i,
  input wire logic param_wr_i,
  input wire logic param_diag_en_i,
  input wire logic param_hw_en_i,
  input wire logic hw_irq_req_i,
  input wire logic job_valid_i,
  input wire logic group_fault_indicator_o,
  input wire logic diag_irq_o,
  input wire logic hw_irq_o,
  input wire logic job_accept_o,
  input wire logic job_reject_o,
  input wire logic diag_buf_entry_o,
  input wire logic data_err_o
);
  logic dia_en_ff;
  logic hw_en_ff;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dia_en_ff <= 1'b0;
      hw_en_ff <= 1'b0;
    end else if (param_wr_i) begin
      dia_en_ff <= param_diag_en_i;
      hw_en_ff <= param_hw_en_i;
    end
  end
  sequence s_on;
    !(|fault_i) ##1 (|fault_i)[*6];
  endsequence
  sequence s_off;
    (|fault_i) ##1 !(|fault_i)[*6];
  endsequence
  AST_IND_ON: assert property (s_on |-> group_fault_indicator_o)
    else $error("indicator not lit");
  AST_IND_OFF: assert property (s_off |-> !group_fault_indicator_o)
    else $error("indicator still lit");
  AST_IRQ_ON: assert property ((s_on ##0 $past(dia_en_ff)) |-> diag_irq_o)
    else $error("diag irq missing");
  AST_IRQ_OFF: assert property (!dia_en_ff && !$past(dia_en_ff) && !$past(dia_en_ff, 2) |-> !diag_irq_o)
    else $error("diag irq while disabled");
  AST_JOB: assert property (job_valid_i |=> job_accept_o ^ job_reject_o)
    else $error("job not answered once");
  AST_JOB_NONE: assert property (!job_valid_i |=> !job_accept_o && !job_reject_o)
    else $error("job answer without job");
  AST_DATA: assert property (data_err_o |-> job_reject_o && diag_buf_entry_o)
    else $error("data error not rejected");
  AST_HW: assert property (hw_irq_o == ($past(hw_irq_req_i) && $past(hw_en_ff)))
    else $error("hw irq mismatch");
endmodule
bind fdr_core fdr_monitor mon_u (.sys_clk_i, .rst_n_i, .fault_i, .param_wr_i, .param_diag_en_i,
  .param_hw_en_i, .hw_irq_req_i, .job_valid_i, .group_fault_indicator_o, .diag_irq_o, .hw_irq_o,
  .job_accept_o, .job_reject_o, .diag_buf_entry_o, .data_err_o);
`default_nettype wire

//--- fdr_cpu_model.sv
// Purpose: controller model, takes the diag interrupt
// Assumes: handler presence set by the bench
// Notes: keeps the last short record as start info
`timescale 1ns/1ps
`default_nettype none
module fdr_cpu_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic handler_cfg_i,
  input wire logic diag_irq_i,
  input wire logic [31:0] short_rec_i,
  output logic handler_installed_o,
  output logic [31:0] start_info_o,
  output logic [7:0] irq_cnt_o
);
  assign handler_installed_o = handler_cfg_i;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      start_info_o <= '0;
      irq_cnt_o <= 8'h00;
    end else if (diag_irq_i) begin
      start_info_o <= short_rec_i;
      irq_cnt_o <= irq_cnt_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- test_fault_diagnostic_reporting.sv
// Purpose: self-checking bench of fdr_core
// Assumes: inputs move 1 ns after the edge
// Notes: fault checks wait past the pin latency
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin n_fail++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_fault_diagnostic_reporting;
  logic sys_clk_i, rst_n_i, param_wr_i, param_diag_en_i, param_hw_en_i, hw_irq_req_i, job_valid_i;
  logic hnd, den, hen, grp, dirq, hirq, run, acc, rej, dbe, derr, handler_installed_i, bad, oor;
  logic [31:0] srec, sinfo;
  logic [127:0] lrec;
  logic [7:0] icnt;
  fdr_pkg::fdr_fault_t fault_i, f;
  fdr_pkg::fdr_job_t job_i;
  fdr_pkg::fdr_class_t cls;
  int seed = 32'hc7ba;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int lo, hi, cmp, ch;
  fdr_core dut_u (.sys_clk_i, .rst_n_i, .fault_i, .param_wr_i, .param_diag_en_i, .param_hw_en_i,
    .handler_installed_i, .hw_irq_req_i, .job_valid_i, .job_i, .group_fault_indicator_o(grp),
    .diag_irq_o(dirq), .hw_irq_o(hirq), .count_run_o(run), .short_diagnostic_record_o(srec),
    .long_diagnostic_record_o(lrec), .job_accept_o(acc), .job_reject_o(rej),
    .diag_buf_entry_o(dbe), .data_err_o(derr), .err_class_o(cls));
  fdr_cpu_model cpu_u (.sys_clk_i, .rst_n_i, .handler_cfg_i(hnd), .diag_irq_i(dirq),
    .short_rec_i(srec), .handler_installed_o(handler_installed_i), .start_info_o(sinfo), .irq_cnt_o(icnt));
  function automatic logic [127:0] exp_rec(input fdr_pkg::fdr_fault_t v);
    logic [127:0] r;
    r = '0;
    r[0] = |v;
    r[1] = v.watchdog | v.hw_irq_lost;
    r[2] = v.no_param | v.bad_param | (|v[19:4]);
    r[3] = |v[19:4];
    r[7:6] = {v.bad_param, v.no_param};
    r[15:8] = 8'h18;
    r[19] = v.watchdog;
    r[30] = v.hw_irq_lost;
    r[55:32] = 24'h080876;
    r[63:56] = v.enc_supply | v.enc_signal;
    for (int c = 0; c < 8; c++) begin
      r[68 + 8 * c] = v.enc_supply[c];
      r[70 + 8 * c] = v.enc_signal[c];
    end
    return r;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic set_en(input logic d, input logic h);
    {param_diag_en_i, param_hw_en_i, param_wr_i, den, hen} = {d, h, 1'b1, d, h};
    @(posedge sys_clk_i);
    #1;
    param_wr_i = 1'b0;
  endtask
  task automatic fault_case(input fdr_pkg::fdr_fault_t v, input logic h);
    logic [7:0] c0;
    logic [127:0] e;
    c0 = icnt;
    e = exp_rec(v);
    hnd = h;
    fault_i = v;
    repeat (8) @(posedge sys_clk_i);
    #1;
    `CHK("indicator", 1'b1, grp)
    `CHK("long record", e, lrec)
    `CHK("short record", e[31:0], srec)
    `CHK("count run", h, run)
    `CHK("class", (v.no_param | v.bad_param) ? fdr_pkg::FDR_CLS_MOD_PARAM : fdr_pkg::FDR_CLS_DIAG, cls)
    `CHK("irq count", c0 + {7'h00, den}, icnt)
    if (den) `CHK("start info", e[31:0], sinfo)
    fault_i = '0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    `CHK("indicator off", 1'b0, grp)
    `CHK("irq count off", c0 + {6'h00, den, 1'b0}, icnt)
    $display("fault test done %0h", v);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {rst_n_i, param_wr_i, param_diag_en_i, param_hw_en_i, hw_irq_req_i, job_valid_i, hnd, den, hen} = '0;
    fault_i = '0;
    job_i = '0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("idle record", exp_rec('0), lrec)
    fault_case(20'h1, 1'b0);
    set_en(1'b1, 1'b1);
    for (int k = 0; k < 7; k++) begin
      ch = $random(seed) & 7;
      case (k)
        4: f = 20'h10 << ch;
        5: f = 20'h1000 << ch;
        6: f = 20'hFF011;
        default: f = 20'h1 << k;
      endcase
      fault_case(f, k[0]);
    end
    rst_n_i = 1'b0;
    {den, hen} = 2'b00;
    repeat (3) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("reset record", exp_rec('0), lrec)
    fault_case(20'h2, 1'b1);
    set_en(1'b0, 1'b1);
    fault_case(20'h4, 1'b1);
    job_valid_i = 1'b1;
    for (int i = 0; i < 24; i++) begin
      {lo, hi, cmp} = {$random(seed), $random(seed), $random(seed)};
      if (i % 4 != 3 && lo > hi) {lo, hi} = {hi, lo};
      case (i % 4)
        0: cmp = lo;
        1: cmp = hi;
        2: cmp = hi + 1;
        default: ;
      endcase
      job_i = {3'(i), cmp, lo, hi};
      hw_irq_req_i = 1'($random(seed));
      bad = lo > hi;
      oor = cmp < lo || cmp > hi;
      @(posedge sys_clk_i);
      #1;
      `CHK("accept", !(bad | oor), acc)
      `CHK("reject entry", {2{bad | oor}}, {rej, dbe})
      `CHK("data error", !bad & oor, derr)
      `CHK("hw irq", hw_irq_req_i & hen, hirq)
      `CHK("job class", bad ? fdr_pkg::FDR_CLS_CHAN_PARAM : oor ? fdr_pkg::FDR_CLS_DATA : fdr_pkg::FDR_CLS_STATUS, cls)
    end
    job_valid_i = 1'b0;
    $display("job test done");
    test_done();
  end
endmodule
`default_nettype wire
